// file: rtl/scp_pkg.sv
/*
  Shared constants and the state record of the serial controller pin
  interface: input synchroniser bit positions, AXI4-Lite register offsets,
  configuration field positions, mode codes and counts.
  Assumes a single 125 MHz clock domain and an active-low async reset.
*/
package scp_pkg;
  // Positions of the asynchronous inputs in the synchroniser vector.
  localparam int NS = 36;
  localparam int I_RD = 0;
  localparam int I_WR = 1;
  localparam int I_CE = 2;
  localparam int I_CHS = 3;
  localparam int I_DC = 4;
  localparam int I_ACK = 5;
  localparam int I_EI = 6;
  localparam int I_AS = 7;
  localparam int I_DS = 8;
  localparam int I_RW = 9;
  localparam int I_CSL = 10;
  localparam int I_CSH = 11;
  localparam int I_SYNC = 12;
  localparam int I_RX_TX_CLK_PIN = 14;
  localparam int I_TX_RX_CLK_PIN = 16;
  localparam int I_RXD = 18;
  localparam int I_DAT = 20;
  localparam int I_MAD = 28;
  // Idle level of the vector: active-low strobes and sync pins high.
  localparam logic [NS-1:0] IN_IDLE = 36'h0000035E7;
  // Register byte offsets.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CFG0 = 8'h04;
  localparam logic [7:0] A_CFG1 = 8'h08;
  localparam logic [7:0] A_DIV0 = 8'h0C;
  localparam logic [7:0] A_DIV1 = 8'h10;
  localparam logic [7:0] A_IRQ = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam logic [7:0] A_PAR = 8'h1C;
  // Channel configuration fields.
  localparam int F_DTR = 0;
  localparam int F_DREQ = 1;
  localparam int F_RTS = 2;
  localparam int F_AUTO = 3;
  localparam int F_MODE = 4;
  localparam int F_XTAL = 6;
  localparam int F_WREQ = 7;
  localparam int F_FAC = 8;
  localparam int F_RXS = 10;
  localparam int F_TXS = 12;
  localparam int F_TOS = 14;
  localparam int F_TDIR = 16;
  localparam int F_BSRC = 17;
  localparam int F_PAT = 24;
  // Control register fields and interrupt register fields.
  localparam int C_MUX = 0;
  localparam int C_VEC = 8;
  localparam int Q_CLR = 0;
  localparam int Q_SET = 4;
  localparam int Q_IUS = 8;
  // Modes, clock sources, patterns and counts.
  localparam logic [1:0] M_ASYNC = 2'h0;
  localparam logic [1:0] M_EXT = 2'h1;
  localparam logic [1:0] M_INT = 2'h2;
  localparam logic [1:0] M_SDLC = 2'h3;
  localparam logic [1:0] S_RX_TX_CLK_PIN = 2'h0;
  localparam logic [1:0] S_TX_RX_CLK_PIN = 2'h1;
  localparam logic [1:0] S_BRG = 2'h2;
  localparam logic [7:0] FLAG_PAT = 8'h7E;
  localparam logic [2:0] TX_GAP = 3'h3;
  localparam logic [5:0] FAC_X1 = 6'h00;
  localparam logic [5:0] FAC_X16 = 6'h0F;
  localparam logic [5:0] FAC_X32 = 6'h1F;
  localparam logic [5:0] FAC_X64 = 6'h3F;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // Complete state of the block.
  typedef struct packed {
    logic [NS-1:0] s1, s2, s3, filt, fp;
    logic [15:0] ctrl;
    logic [1:0][31:0] cfg;
    logic [1:0][15:0] div, brg;
    logic [1:0][5:0] fdiv;
    logic [1:0][2:0] gap;
    logic [1:0][7:0] shift, edges, start, pdat, pcmd;
    logic [1:0] match, asm, rxt, txt, trxq, rts, sh;
    logic [3:0] pend, under_service_flag;
    logic [7:0] laddr, rcnt, busq, awa;
    logic lcs, srst, ackq, oe_np, oe_mp, awg, wg, bv, rv;
    logic [31:0] wd, rd;
    logic [3:0] ws;
    logic [1:0] br, rr;
  } scp_state_type;
endpackage : scp_pkg

// file: rtl/scp_top.sv
/*
  Pin interface of a dual-channel serial controller: both host bus styles,
  interrupt daisy chain, modem and request outputs, sync pin and clock pin
  selection, with an AXI4-Lite slave for configuration and status.
  Assumes the serial data paths sit outside and supply transmitter empty,
  DMA request and wait levels on ref_clk_i; all pins are asynchronous.
*/
`timescale 1ns/1ns
module scp_top (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Strobe host bus.
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic ce_n_i,
  input wire logic chan_sel_i,
  input wire logic dc_sel_i,
  input wire logic [7:0] data_bus_i,
  output logic [7:0] data_bus_o,
  output logic data_bus_oe_o,
  // Multiplexed host bus.
  input wire logic addr_strobe_n_i,
  input wire logic data_strobe_n_i,
  input wire logic rw_i,
  input wire logic chip_select_low_n_i,
  input wire logic chip_select_high_i,
  input wire logic [7:0] mux_addr_data_bus_i,
  output logic [7:0] mux_addr_data_bus_o,
  output logic mux_addr_data_bus_oe_o,
  // Interrupt daisy chain.
  input wire logic chain_enable_in_i,
  output logic chain_enable_out_o,
  input wire logic irq_ack_n_i,
  output logic irq_n_o,
  output logic irq_n_oe_o,
  // Per-channel pins.
  output logic [1:0] dtr_req_n_o,
  output logic [1:0] rts_n_o,
  output logic [1:0] wait_req_o,
  output logic [1:0] wait_req_oe_o,
  input wire logic [1:0] sync_i,
  output logic [1:0] sync_o,
  output logic [1:0] sync_oe_o,
  input wire logic [1:0] rx_tx_clk_pin_i,
  input wire logic [1:0] tx_rx_clk_pin_i,
  output logic [1:0] tx_rx_clk_pin_o,
  output logic [1:0] tx_rx_clk_pin_oe_o,
  input wire logic [1:0] rx_data_i,
  // Serial data path side.
  input wire logic [1:0] tx_empty_i,
  input wire logic [1:0] dma_req_i,
  input wire logic [1:0] wait_i,
  output logic [1:0] rx_tick_o,
  output logic [1:0] tx_tick_o,
  output logic [1:0] assembly_start_o
);
  import scp_pkg::*;

  scp_state_type st;
  scp_state_type n;
  logic [NS-1:0] in_vec, f, p;
  logic mux, ack, ei, soft_rst, ack_rd, np_rd, np_wr, mp_sel, mp_rd, mp_wr;
  logic as_rise, wch, wdc, rch, rdc;
  logic [7:0] wbyte;

  // Merges a write into a register honouring the byte strobes.
  function automatic logic [31:0] scp_apply(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b+:8] = d[8*b+:8];
    end
    return r;
  endfunction : scp_apply

  // Picks one clock tick from the selectable sources; 3 falls back to the RX/TX clock pin.
  function automatic logic scp_pick(input logic [1:0] sel,
      input logic rtx, input logic trx, input logic brg);
    logic r;
    case (sel)
      S_RX_TX_CLK_PIN: r = rtx;
      S_TX_RX_CLK_PIN: r = trx;
      S_BRG: r = brg;
      default: r = rtx;
    endcase
    return r;
  endfunction : scp_pick

  // Raw pins gathered for the synchroniser.
  assign in_vec = {mux_addr_data_bus_i, data_bus_i, rx_data_i,
                   tx_rx_clk_pin_i, rx_tx_clk_pin_i, sync_i,
                   chip_select_high_i, chip_select_low_n_i, rw_i,
                   data_strobe_n_i, addr_strobe_n_i, chain_enable_in_i,
                   irq_ack_n_i, dc_sel_i, chan_sel_i, ce_n_i, wr_n_i, rd_n_i};

  // Bus decode works only on filtered inputs and their previous value.
  assign f = st.filt;
  assign p = st.fp;
  assign mux = st.ctrl[C_MUX];
  assign ack = ~f[I_ACK];
  assign ei = f[I_EI];
  assign soft_rst = mux ? (~f[I_AS] & ~f[I_DS])
                        : (~f[I_RD] & ~f[I_WR]);
  assign ack_rd = ack & ei & (mux ? (~f[I_DS] & f[I_RW]) : ~f[I_RD]);
  assign np_rd = ~mux & ~ack & ~f[I_CE] & ~f[I_RD] & f[I_WR];
  assign np_wr = ~mux & ~p[I_CE] & ~p[I_WR] & f[I_WR] & p[I_RD];
  assign mp_sel = ~st.lcs & f[I_CSH];
  assign mp_rd = mux & ~ack & mp_sel & ~f[I_DS] & f[I_RW] & f[I_AS];
  assign mp_wr = mux & mp_sel & ~p[I_DS] & f[I_DS] & ~p[I_RW] & p[I_AS];
  assign as_rise = ~p[I_AS] & f[I_AS];
  // Channel and data/command selection for both bus styles.
  assign rch = mux ? st.laddr[0] : f[I_CHS];
  assign rdc = mux ? st.laddr[1] : f[I_DC];
  assign wch = mux ? st.laddr[0] : p[I_CHS];
  assign wdc = mux ? st.laddr[1] : p[I_DC];
  assign wbyte = mux ? p[I_MAD+:8] : p[I_DAT+:8];

  // Next-state logic for the whole block.
  always_comb begin
    logic [1:0] mode;
    logic rtx, trx, bs, rxr, txa, rxb;
    logic [5:0] tc;
    logic [7:0] sh8, pat, wa;
    logic [3:0] pset, pclr, low;
    logic [31:0] rdv;
    logic [1:0] rsp;
    mode = M_ASYNC;
    rtx = 1'b0;
    trx = 1'b0;
    bs = 1'b0;
    rxr = 1'b0;
    txa = 1'b0;
    rxb = 1'b0;
    tc = FAC_X1;
    sh8 = 8'h00;
    pat = 8'h00;
    wa = 8'h00;
    pset = 4'h0;
    pclr = 4'h0;
    low = 4'h0;
    rdv = 32'h0000_0000;
    rsp = RESP_OK;
    n = st;
    // Three stages; a bit counts once stages two and three agree.
    n.s1 = in_vec;
    n.s2 = st.s1;
    n.s3 = st.s2;
    n.fp = st.filt;
    n.filt = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.filt);
    for (int c = 0; c < 2; c++) begin
      mode = st.cfg[c][F_MODE+:2];
      rtx = f[I_RX_TX_CLK_PIN+c] & ~p[I_RX_TX_CLK_PIN+c];
      trx = f[I_TX_RX_CLK_PIN+c] & ~p[I_TX_RX_CLK_PIN+c] & ~st.cfg[c][F_TDIR];
      // Baud generator runs from the master clock or the clock pin.
      bs = 1'b0;
      if (~st.cfg[c][F_BSRC] | rtx) begin
        if (st.brg[c] == 16'h0000) begin
          n.brg[c] = st.div[c];
          bs = 1'b1;
        end else begin
          n.brg[c] = st.brg[c] - 16'h0001;
        end
      end
      // Receive clock, divided by the clock factor in async mode.
      rxr = scp_pick(st.cfg[c][F_RXS+:2], rtx, trx, bs);
      case (st.cfg[c][F_FAC+:2])
        2'h1: tc = FAC_X16;
        2'h2: tc = FAC_X32;
        2'h3: tc = FAC_X64;
        default: tc = FAC_X1;
      endcase
      if (mode != M_ASYNC) tc = FAC_X1;
      rxb = 1'b0;
      if (rxr) begin
        if (st.fdiv[c] >= tc) begin
          n.fdiv[c] = 6'h00;
          rxb = 1'b1;
        end else begin
          n.fdiv[c] = st.fdiv[c] + 6'h01;
        end
        n.edges[c] = st.edges[c] + 8'h01;
      end
      n.rxt[c] = rxb;
      // A transmit tick is refused until three idle cycles have passed.
      txa = scp_pick(st.cfg[c][F_TXS+:2], rtx, trx, bs) &
            (st.gap[c] == 3'h0);
      n.txt[c] = txa;
      if (txa) n.gap[c] = TX_GAP;
      else if (st.gap[c] != 3'h0) n.gap[c] = st.gap[c] - 3'h1;
      // Clock pin output toggles on the chosen source.
      case (st.cfg[c][F_TOS+:2])
        2'h1: n.trxq[c] = st.trxq[c] ^ bs;
        2'h2: n.trxq[c] = st.trxq[c] ^ txa;
        default: n.trxq[c] = st.trxq[c] ^ rtx;
      endcase
      // Pattern search; the match stands for one receive clock period.
      sh8 = {st.shift[c][6:0], f[I_RXD+c]};
      pat = (mode == M_SDLC) ? FLAG_PAT : st.cfg[c][F_PAT+:8];
      if (rxb) n.shift[c] = sh8;
      if ((mode != M_INT && mode != M_SDLC) || st.cfg[c][F_XTAL]) begin
        n.match[c] = 1'b0;
      end else if (rxb) begin
        n.match[c] = (sh8 == pat);
      end
      // Sync input: status only in async, assembly start in external.
      n.asm[c] = 1'b0;
      if (~st.cfg[c][F_XTAL] && mode == M_ASYNC) begin
        n.sh[c] = ~f[I_SYNC+c];
      end
      if (~st.cfg[c][F_XTAL] && mode == M_EXT &&
          p[I_SYNC+c] && ~f[I_SYNC+c]) begin
        n.start[c] = st.edges[c];
        n.asm[c] = 1'b1;
      end
      pset[2*c] = (n.match[c] & ~st.match[c]) | n.asm[c];
      // Request-to-send hold.
      if (mode != M_ASYNC || ~st.cfg[c][F_AUTO] || st.cfg[c][F_RTS]) begin
        n.rts[c] = st.cfg[c][F_RTS];
      end else if (tx_empty_i[c]) begin
        n.rts[c] = 1'b0;
      end
    end
    // Host bus: address latch, data latches and drivers.
    if (mux && as_rise) begin
      n.laddr = f[I_MAD+:8];
      n.lcs = f[I_CSL];
    end
    if (np_wr | mp_wr) begin
      if (wdc) n.pdat[wch] = wbyte;
      else n.pcmd[wch] = wbyte;
    end
    n.busq = ack_rd ? st.ctrl[C_VEC+:8]
                    : (rdc ? st.pdat[rch] : st.pcmd[rch]);
    n.oe_np = ~mux & (np_rd | ack_rd);
    n.oe_mp = mux & (mp_rd | ack_rd);
    // Under-service goes to the lowest-numbered pending source at ack read.
    n.ackq = ack_rd;
    low = st.pend & (~st.pend + 4'h1);
    if (ack_rd && ~st.ackq) n.under_service_flag = st.under_service_flag | low;
    // AXI4-Lite write channel.
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      n.awg = 1'b1;
      n.awa = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      n.wg = 1'b1;
      n.wd = s_axi_wdata_i;
      n.ws = s_axi_wstrb_i;
    end
    if (st.bv && s_axi_bready_i) n.bv = 1'b0;
    if (st.awg && st.wg && ~st.bv) begin
      n.awg = 1'b0;
      n.wg = 1'b0;
      n.bv = 1'b1;
      n.br = RESP_OK;
      wa = {st.awa[7:2], 2'b00};
      case (wa)
        A_CTRL: n.ctrl = 16'(scp_apply({16'h0000, st.ctrl}, st.wd, st.ws));
        A_CFG0: n.cfg[0] = scp_apply(st.cfg[0], st.wd, st.ws);
        A_CFG1: n.cfg[1] = scp_apply(st.cfg[1], st.wd, st.ws);
        A_DIV0: n.div[0] = 16'(scp_apply({16'h0000, st.div[0]}, st.wd,
                                         st.ws));
        A_DIV1: n.div[1] = 16'(scp_apply({16'h0000, st.div[1]}, st.wd,
                                         st.ws));
        A_IRQ: begin
          if (st.ws[0]) pclr = st.wd[Q_CLR+:4];
          if (st.ws[0]) pset = pset | st.wd[Q_SET+:4];
          if (st.ws[1] && st.wd[Q_IUS]) begin
            n.under_service_flag = n.under_service_flag & ~(st.under_service_flag & (~st.under_service_flag + 4'h1));
          end
        end
        A_STAT, A_PAR: n.br = RESP_OK;
        default: n.br = RESP_ERR;
      endcase
    end
    // Pending flags: a set in the same cycle as a clear wins.
    n.pend = (st.pend & ~pclr) | pset;
    // AXI4-Lite read channel.
    if (st.rv && s_axi_rready_i) n.rv = 1'b0;
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      case ({s_axi_araddr_i[7:2], 2'b00})
        A_CTRL: rdv = {16'h0000, st.ctrl[C_VEC+:8], 7'h00, st.ctrl[C_MUX]};
        A_CFG0: rdv = st.cfg[0];
        A_CFG1: rdv = st.cfg[1];
        A_DIV0: rdv = {16'h0000, st.div[0]};
        A_DIV1: rdv = {16'h0000, st.div[1]};
        A_IRQ: rdv = {24'h000000, st.under_service_flag, st.pend};
        A_STAT: rdv = {st.start[1], st.start[0], st.rcnt, 6'h00, st.sh};
        A_PAR: rdv = {st.pcmd[1], st.pdat[1], st.pcmd[0], st.pdat[0]};
        default: rsp = RESP_ERR;
      endcase
      n.rv = 1'b1;
      n.rd = rdv;
      n.rr = rsp;
    end
    // Coincident strobes reset the device state, counted once per event.
    n.srst = soft_rst;
    if (soft_rst) begin
      n.cfg = '0;
      n.pend = 4'h0;
      n.under_service_flag = 4'h0;
      n.pdat = '0;
      n.pcmd = '0;
      if (~st.srst) n.rcnt = st.rcnt + 8'h01;
    end
  end

  // State register; synchronisers start at the idle pin levels.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
      st.s1 <= IN_IDLE;
      st.s2 <= IN_IDLE;
      st.s3 <= IN_IDLE;
      st.filt <= IN_IDLE;
      st.fp <= IN_IDLE;
    end else begin
      st <= n;
    end
  end

  // Bus slave handshakes and answers.
  assign s_axi_awready_o = ~st.awg & ~st.bv;
  assign s_axi_wready_o = ~st.wg & ~st.bv;
  assign s_axi_bvalid_o = st.bv;
  assign s_axi_bresp_o = st.br;
  assign s_axi_arready_o = ~st.rv;
  assign s_axi_rvalid_o = st.rv;
  assign s_axi_rdata_o = st.rd;
  assign s_axi_rresp_o = st.rr;

  // Host data drivers and interrupt chain.
  assign data_bus_o = st.busq;
  assign data_bus_oe_o = st.oe_np;
  assign mux_addr_data_bus_o = st.busq;
  assign mux_addr_data_bus_oe_o = st.oe_mp;
  assign chain_enable_out_o = ei & ~(|st.under_service_flag) & ~(ack & |st.pend);
  assign irq_n_o = 1'b0;
  assign irq_n_oe_o = ei & (|st.pend);
  assign rx_tick_o = st.rxt;
  assign tx_tick_o = st.txt;
  assign assembly_start_o = st.asm;

  // Per-channel pin drivers.
  for (genvar c = 0; c < 2; c++) begin : g_ch
    assign dtr_req_n_o[c] = st.cfg[c][F_DREQ] ? ~dma_req_i[c]
                                              : ~st.cfg[c][F_DTR];
    assign rts_n_o[c] = ~st.rts[c];
    // Wait drives low only, request drives both levels.
    assign wait_req_o[c] = st.cfg[c][F_WREQ] & ~dma_req_i[c];
    assign wait_req_oe_o[c] = st.cfg[c][F_WREQ] | wait_i[c];
    assign sync_o[c] = ~st.match[c];
    assign sync_oe_o[c] = ~st.cfg[c][F_XTAL] &
        (st.cfg[c][F_MODE+:2] == M_INT || st.cfg[c][F_MODE+:2] == M_SDLC);
    assign tx_rx_clk_pin_o[c] = st.trxq[c];
    assign tx_rx_clk_pin_oe_o[c] = st.cfg[c][F_TDIR];
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_ack_read;
    ack_rd && !st.ackq && !soft_rst;
  endsequence
  sequence s_async_auto_drop;
    st.cfg[0][F_MODE+:2] == M_ASYNC && st.cfg[0][F_AUTO] &&
    !st.cfg[0][F_RTS] && !tx_empty_i[0] && st.rts[0];
  endsequence

  a_ius_grab: assert property (s_ack_read ##0 (|st.pend) |=> (|st.under_service_flag))
    else $error("ack read did not set an under-service flag");
  a_chain_block: assert property (s_ack_read ##0 (|st.pend)
      |=> !chain_enable_out_o)
    else $error("enable-out high after an acknowledged request");
  a_vector_out: assert property (ack_rd && !soft_rst
      |=> st.busq == $past(st.ctrl[C_VEC+:8]))
    else $error("vector not presented during ack read");
  a_irq_pull: assert property ((|st.pend) && ei
      |-> irq_n_oe_o && !irq_n_o)
    else $error("interrupt output not pulled low");
  a_tx_spacing: assert property (st.txt[0] |=> !st.txt[0] [*3])
    else $error("transmit ticks closer than four clocks");
  a_rts_follow: assert property (st.cfg[0][F_MODE+:2] != M_ASYNC
      && !soft_rst |=> rts_n_o[0] == !$past(st.cfg[0][F_RTS]))
    else $error("request-to-send does not follow its bit");
  a_rts_hold: assert property (s_async_auto_drop |=> !rts_n_o[0])
    else $error("request-to-send released before transmitter empty");
  a_strobe_reset: assert property (soft_rst
      |=> st.cfg == '0 && st.pend == 4'h0)
    else $error("coincident strobes did not reset the device");
  a_as_latch: assert property (mux && as_rise
      |=> st.laddr == $past(f[I_MAD+:8]))
    else $error("address not latched on address strobe rise");
endmodule : scp_top

// file: verif/scp_host_model.sv
/* Host CPU model on the strobe bus of the pin interface.
   Assumes strobes are driven right after rising edges of clk_i. */
`timescale 1ns/1ns
module scp_host_model (
  // Clock.
  input wire logic clk_i,
  // Strobe bus towards the device.
  output logic rd_n_o = 1'b1,
  output logic wr_n_o = 1'b1,
  output logic ce_n_o = 1'b1,
  output logic [7:0] data_o = 8'h00,
  // Device data drivers.
  input wire logic [7:0] data_i,
  input wire logic data_oe_i
);
  // One access; each phase lasts eight clocks, past the input filter.
  task automatic access(input logic rd, input logic wr, input logic ce,
      input logic [7:0] d, output logic [7:0] q, output logic oe);
    ce_n_o <= ~ce;
    rd_n_o <= ~rd;
    wr_n_o <= ~wr;
    data_o <= d;
    repeat (8) @(posedge clk_i);
    q = data_i;
    oe = data_oe_i;
    {ce_n_o, rd_n_o, wr_n_o} <= 3'h7;
    data_o <= ~d; // Released lines show the inverse of the last byte.
    repeat (8) @(posedge clk_i);
  endtask : access
endmodule : scp_host_model

// file: verif/scp_top_tb.sv
/* Self-checking bench of scp_top: AXI4-Lite tasks, modem pins,
   interrupt chain and soft resets. Assumes the host model beside it. */
`timescale 1ns/1ns
module scp_top_tb;
  import scp_pkg::*;
  logic ref_clk_i = 1'b0, resetn_i = 1'b0, s_axi_awvalid_i = 1'b0;
  logic s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0, s_axi_rready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, chan_sel_i = 1'b0, dc_sel_i = 1'b1;
  logic addr_strobe_n_i = 1'b1, data_strobe_n_i = 1'b1, rw_i = 1'b1;
  logic chip_select_low_n_i = 1'b1, chip_select_high_i = 1'b0;
  logic chain_enable_in_i = 1'b0, irq_ack_n_i = 1'b1;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [7:0] mux_addr_data_bus_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic [1:0] sync_i = 2'h3, rx_tx_clk_pin_i = 2'h0, tx_rx_clk_pin_i = 2'h0;
  logic [1:0] rx_data_i = 2'h3, tx_empty_i = 2'h0, dma_req_i = 2'h0;
  logic [1:0] wait_i = 2'h2;
  logic rd_n_i, wr_n_i, ce_n_i, data_bus_oe_o, chain_enable_out_o, irq_n_o;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, mux_addr_data_bus_oe_o, irq_n_oe_o, oe;
  logic [7:0] data_bus_i, data_bus_o, mux_addr_data_bus_o, q;
  logic [31:0] s_axi_rdata_o, rd;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, dtr_req_n_o, rts_n_o, wait_req_o;
  logic [1:0] wait_req_oe_o, sync_o, sync_oe_o, tx_rx_clk_pin_o, rr;
  logic [1:0] tx_rx_clk_pin_oe_o, rx_tick_o, tx_tick_o, assembly_start_o;
  int err_count = 0;
  int compares = 0;
  int asm_seen = 0;
  scp_top u_scp_top (.*);
  scp_host_model u_scp_host_model (.clk_i(ref_clk_i), .rd_n_o(rd_n_i),
    .wr_n_o(wr_n_i), .ce_n_o(ce_n_i), .data_o(data_bus_i),
    .data_i(data_bus_o), .data_oe_i(data_bus_oe_o));
  // Counts assembly-start pulses of channel 0.
  always @(posedge ref_clk_i) asm_seen <= asm_seen + assembly_start_o[0];
  // Free-running 125 MHz clock.
  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // Compares a value with its expectation and counts both.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // AXI4-Lite write; ready is sampled at the falling edge before the take.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    {pa, pw} = 2'h3;
    {s_axi_awaddr_i, s_axi_wdata_i} <= {a, d};
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
    while (pa || pw) begin
      @(negedge ref_clk_i);
      {ta, tw} = {pa && s_axi_awready_o, pw && s_axi_wready_o};
      @(posedge ref_clk_i);
      if (ta) begin
        s_axi_awvalid_i <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        s_axi_wvalid_i <= 1'b0;
        pw = 1'b0;
      end
    end
    do begin
      @(negedge ref_clk_i);
      ta = s_axi_bvalid_o;
      @(posedge ref_clk_i);
    end while (!ta);
    s_axi_bready_i <= 1'b0;
    // Lets an edge pass so a following call never reassigns bready at once.
    @(posedge ref_clk_i);
  endtask : axw
  // AXI4-Lite read; data and response taken with rvalid.
  task automatic axr(input logic [7:0] a);
    logic t;
    {s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i} <= {a, 2'h3};
    do begin
      @(negedge ref_clk_i);
      t = s_axi_arready_o;
      @(posedge ref_clk_i);
    end while (!t);
    s_axi_arvalid_i <= 1'b0;
    do begin
      @(negedge ref_clk_i);
      {t, rd, rr} = {s_axi_rvalid_o, s_axi_rdata_o, s_axi_rresp_o};
      @(posedge ref_clk_i);
    end while (!t);
    s_axi_rready_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : axr
  // Modem outputs: terminal ready, request to send, wait or request.
  task automatic t_modem;
    chk(rts_n_o, 2'h3);
    chk(wait_req_oe_o, 2'h2);
    axw(A_CFG0, 32'h25);
    repeat (3) @(posedge ref_clk_i);
    chk(dtr_req_n_o, 2'h2);
    chk(rts_n_o, 2'h2);
    axw(A_CFG0, 32'h0C);
    axw(A_CFG0, 32'h08);
    repeat (6) @(posedge ref_clk_i);
    chk(rts_n_o[0], 1'b0);
    tx_empty_i <= 2'h3;
    repeat (4) @(posedge ref_clk_i);
    chk(rts_n_o[0], 1'b1);
    axw(A_CFG1, 32'h82);
    dma_req_i <= 2'h2;
    repeat (2) @(posedge ref_clk_i);
    chk({dtr_req_n_o[1], wait_req_oe_o[1], wait_req_o[1]}, 3'h2);
    $display("done modem");
  endtask : t_modem
  // Interrupt request, acknowledge cycle and chain output.
  task automatic t_irq;
    axw(A_CTRL, 32'hA500);
    axw(A_IRQ, 32'h10);
    repeat (6) @(posedge ref_clk_i);
    chk({irq_n_oe_o, chain_enable_out_o}, 2'h0);
    chain_enable_in_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    chk(irq_n_oe_o, 1'b1);
    irq_ack_n_i <= 1'b0;
    u_scp_host_model.access(1'b1, 1'b0, 1'b0, 8'h00, q, oe);
    chk({oe, q}, 9'h1A5);
    irq_ack_n_i <= 1'b1;
    axr(A_IRQ);
    chk(rd[7:4], 4'h1);
    chk(chain_enable_out_o, 1'b0);
    axw(A_IRQ, 32'h101);
    repeat (6) @(posedge ref_clk_i);
    chk({irq_n_oe_o, chain_enable_out_o}, 2'h1);
    $display("done irq");
  endtask : t_irq
  // One receive clock period on channel 0 carrying one data bit.
  task automatic rx_bit(input logic b);
    {rx_tx_clk_pin_i[0], rx_data_i[0]} <= {1'b0, b};
    repeat (4) @(posedge ref_clk_i);
    rx_tx_clk_pin_i[0] <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
  endtask : rx_bit
  // Sync pin as status input, external sync input and flag output.
  task automatic t_sync;
    axw(A_CFG0, 32'h0);
    sync_i <= 2'h2;
    repeat (6) @(posedge ref_clk_i);
    axr(A_STAT);
    chk(rd[1:0], 2'h1);
    sync_i <= 2'h3;
    axr(A_IRQ);
    chk(rd[3:0], 4'h0);
    axw(A_CFG0, 32'h10);
    repeat (3) rx_bit(1'b1);
    sync_i <= 2'h2;
    repeat (2) rx_bit(1'b1);
    sync_i <= 2'h3;
    repeat (6) @(posedge ref_clk_i);
    axr(A_STAT);
    chk(rd[23:16], 8'h03);
    chk(asm_seen, 1);
    axw(A_CFG0, 32'h30);
    chk(sync_oe_o[0], 1'b1);
    for (int i = 7; i >= 0; i--) rx_bit(FLAG_PAT[i]);
    repeat (2) @(posedge ref_clk_i);
    chk(sync_o[0], 1'b0);
    $display("done sync");
  endtask : t_sync
  // Coincident strobes on both bus styles reset the device.
  task automatic t_softrst;
    axw(A_CFG0, 32'h1);
    u_scp_host_model.access(1'b1, 1'b1, 1'b1, 8'h00, q, oe);
    chk(dtr_req_n_o[0], 1'b1);
    axr(A_STAT);
    chk(rd[15:8], 8'h01);
    axw(A_CTRL, 32'h1);
    {addr_strobe_n_i, data_strobe_n_i} <= 2'h0;
    repeat (8) @(posedge ref_clk_i);
    {addr_strobe_n_i, data_strobe_n_i} <= 2'h3;
    repeat (8) @(posedge ref_clk_i);
    axr(A_STAT);
    chk(rd[15:8], 8'h02);
    axr(8'h40);
    chk(rr, RESP_ERR);
    $display("done soft reset");
  endtask : t_softrst
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  // Watchdog far beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_count++;
    give_verdict();
  end
  // Main sequence.
  initial begin
    repeat (6) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    t_modem();
    t_irq();
    t_sync();
    t_softrst();
    give_verdict();
  end
endmodule : scp_top_tb
